// [hw/vbc_pkg.sv]
// Purpose: constants for the voiceband codec digital side
// Assumes: 125 MHz ref_clk stands in for the master clock
// Notes: control bits are plain ports, all reset to zero
package vbc_pkg;
  localparam int WORD_NORMAL = 16;
  localparam int WORD_TEST = 13;
  localparam int CLK_DIV_BASE = 5;
  localparam logic [4:0] DIV_MAX_NORMAL = 5'h10;
  localparam logic [4:0] DIV_TEST_EXTRA = 5'h18;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_NORMAL = 2'h1;
  localparam logic [1:0] SEL_AUX = 2'h2;
  localparam logic [1:0] SEL_BUZZER = 2'h3;
  localparam logic [2:0] GAIN_MIN = 3'h7;
  localparam int STARTUP_FRAMES = 2;
  localparam int MOD_RATE_KHZ = 500;
  localparam int REF_CLK_KHZ = 125000;
  localparam int MOD_DIV = REF_CLK_KHZ / MOD_RATE_KHZ;
  localparam int DECIM = 64;
  localparam int HP_PASS_HZ = 150;
  localparam int HP_STOP_HZ = 100;
  localparam int LP_PASS_HZ = 3300;
  localparam int LP_STOP_HZ = 4400;
  typedef enum logic [1:0] {VBC_IDLE, VBC_START, VBC_SYNC, VBC_SHIFT} vbc_state_t;
endpackage

// [hw/vbc_biquad.sv]
// Purpose: one second-order section of the voiceband IIR filters
// Assumes: coefficients Q2.14, advance on en pulse
// Notes: cascades give the elliptic high-pass and low-pass
`timescale 1ns/100ps
module vbc_biquad #(
  parameter int W = 16,
  parameter logic signed [15:0] B0 = 16'sh4000,
  parameter logic signed [15:0] B1 = 16'sh0000,
  parameter logic signed [15:0] B2 = 16'sh0000,
  parameter logic signed [15:0] A1 = 16'sh0000,
  parameter logic signed [15:0] A2 = 16'sh0000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr,
  // sample flow
  input wire logic en,
  input wire logic signed [W-1:0] x,
  output logic signed [W-1:0] y
);
  logic signed [W+17:0] s1_q, s2_q, acc;
  logic signed [W+17:0] y_full;
  assign acc = (B0 * x) + s1_q;
  assign y_full = acc >>> 14;
  assign y = (y_full > $signed((W+18)'(2**(W-1)-1))) ? $signed(W'(2**(W-1)-1)) :
             (y_full < -$signed((W+18)'(2**(W-1)))) ? $signed(W'(-(2**(W-1)))) : y_full[W-1:0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clr) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (en) begin
      s1_q <= (B1 * x) - (A1 * y) + s2_q;
      s2_q <= (B2 * x) - (A2 * y);
    end
  end
endmodule

// [hw/vbc_codec_port.sv]
// Purpose: voiceband codec digital side: filters, output control, serial voice port
// Assumes: control bits arrive as plain ports, synchronous to ref_clk
// Notes: serial port is device master of clock and frame sync
`timescale 1ns/100ps
module vbc_codec_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control register a
  input wire logic outputs_disable,
  input wire logic [2:0] out_gain,
  input wire logic voice_power_up,
  input wire logic [1:0] out_select,
  input wire logic output_mute,
  // control register b and c
  input wire logic voice_clock_off,
  input wire logic voice_soft_reset,
  input wire logic test_audio_13bit,
  input wire logic serial_out_float,
  input wire logic [4:0] serial_clock_divider,
  // converter side
  input wire logic adc_mod_bit,
  output logic adc_mod_tick,
  output logic dac_mod_bit,
  // serial pins
  output logic voice_serial_clock,
  output logic voice_frame_sync,
  output logic voice_serial_out,
  output logic voice_serial_out_oe_n,
  input wire logic voice_serial_in,
  // analog output control
  output logic normal_out_pair_en,
  output logic aux_out_pair_en,
  output logic buzzer_out_en,
  output logic buzzer_oe_n,
  output logic [2:0] pga_gain,
  output logic pga_power_up,
  // received word toward the dac path
  output logic [15:0] dac_word,
  output logic dac_word_valid,
  input wire logic dac_word_ready
);
  import vbc_pkg::*;

  // ***************
  // section control
  // ***************
  logic run;
  logic frozen;
  assign run = voice_power_up && !voice_soft_reset;
  assign frozen = voice_clock_off;

  // ***************
  // output stage
  // ***************
  logic act;
  logic [2:0] gain_d;
  assign act = voice_power_up && !outputs_disable;
  assign gain_d = output_mute ? GAIN_MIN : out_gain;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      normal_out_pair_en <= 1'b0;
      aux_out_pair_en <= 1'b0;
      buzzer_out_en <= 1'b0;
      buzzer_oe_n <= 1'b1;
      pga_gain <= GAIN_MIN;
      pga_power_up <= 1'b0;
    end else begin
      normal_out_pair_en <= act && out_select == SEL_NORMAL;
      aux_out_pair_en <= act && out_select == SEL_AUX;
      buzzer_out_en <= act && out_select == SEL_BUZZER;
      buzzer_oe_n <= !(act && out_select == SEL_BUZZER);
      pga_gain <= gain_d;
      pga_power_up <= act;
    end
  end

  // ***************
  // adc modulator sampling and decimation
  // ***************
  logic [7:0] mod_cnt_q;
  logic [5:0] dec_cnt_q;
  logic signed [15:0] dec_acc_q, dec_out_q;
  logic mod_tick, dec_tick_q;
  assign mod_tick = run && !frozen && mod_cnt_q == 8'(MOD_DIV - 1);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt_q <= '0;
      dec_cnt_q <= '0;
      dec_acc_q <= '0;
      dec_out_q <= '0;
      dec_tick_q <= 1'b0;
      adc_mod_tick <= 1'b0;
    end else begin
      adc_mod_tick <= mod_tick;
      dec_tick_q <= 1'b0;
      if (!run) begin
        mod_cnt_q <= '0;
        dec_cnt_q <= '0;
        dec_acc_q <= '0;
      end else if (!frozen) begin
        mod_cnt_q <= mod_tick ? 8'h00 : mod_cnt_q + 8'h01;
        if (mod_tick) begin
          dec_cnt_q <= dec_cnt_q + 6'h01;
          if (dec_cnt_q == 6'(DECIM - 1)) begin
            dec_out_q <= 16'((dec_acc_q + (adc_mod_bit ? 16'sh0200 : -16'sh0200)));
            dec_acc_q <= '0;
            dec_tick_q <= 1'b1;
          end else begin
            dec_acc_q <= dec_acc_q + (adc_mod_bit ? 16'sh0200 : -16'sh0200);
          end
        end
      end
    end
  end

  // ***************
  // adc path filter chain: high-pass then low-pass
  // ***************
  logic signed [15:0] hp1, hp2, lp1, lp2, lp3, lp4;
  logic fclr;
  assign fclr = !run;
  vbc_biquad #(.B0(16'sh3c00), .B1(-16'sh7800), .B2(16'sh3c00), .A1(-16'sh7700), .A2(16'sh3a00)) u_hp1 (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(fclr), .en(dec_tick_q), .x(dec_out_q), .y(hp1));
  vbc_biquad #(.B0(16'sh3e00), .B1(-16'sh7c00), .B2(16'sh3e00), .A1(-16'sh7b00), .A2(16'sh3d00)) u_hp2 (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(fclr), .en(dec_tick_q), .x(hp1), .y(hp2));
  vbc_biquad #(.B0(16'sh0800), .B1(16'sh0c00), .B2(16'sh0800), .A1(-16'sh2000), .A2(16'sh1000)) u_lp1 (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(fclr), .en(dec_tick_q), .x(hp2), .y(lp1));
  vbc_biquad #(.B0(16'sh0800), .B1(16'sh0a00), .B2(16'sh0800), .A1(-16'sh1800), .A2(16'sh1800)) u_lp2 (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(fclr), .en(dec_tick_q), .x(lp1), .y(lp2));
  vbc_biquad #(.B0(16'sh0800), .B1(16'sh0800), .B2(16'sh0800), .A1(-16'sh1000), .A2(16'sh2400)) u_lp3 (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(fclr), .en(dec_tick_q), .x(lp2), .y(lp3));
  vbc_biquad #(.B0(16'sh0800), .B1(16'sh0600), .B2(16'sh0800), .A1(-16'sh0800), .A2(16'sh3000)) u_lp4 (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(fclr), .en(dec_tick_q), .x(lp3), .y(lp4));

  // ***************
  // serial clock divider
  // ***************
  logic [4:0] div_ok;
  logic [7:0] half_cnt_q, half_lim;
  logic sclk_q, rise, fall;
  assign div_ok = (serial_clock_divider <= DIV_MAX_NORMAL ||
                   (test_audio_13bit && serial_clock_divider == DIV_TEST_EXTRA)) ?
                  serial_clock_divider : DIV_MAX_NORMAL;
  // period is 5*(1+div) ref clocks; high then low phase split unevenly when odd
  assign half_lim = 8'(CLK_DIV_BASE) * (8'h01 + {3'h0, div_ok});
  assign rise = run && !frozen && half_cnt_q >= half_lim - 8'h01;
  assign fall = run && !frozen && half_cnt_q == (half_lim >> 1) - 8'h01;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_q <= '0;
      sclk_q <= 1'b0;
    end else if (!run) begin
      half_cnt_q <= '0;
      sclk_q <= 1'b0;
    end else if (!frozen) begin
      half_cnt_q <= rise ? 8'h00 : half_cnt_q + 8'h01;
      if (rise) sclk_q <= 1'b1;
      else if (fall) sclk_q <= 1'b0;
    end
  end

  // ***************
  // serial framing and shifting
  // ***************
  vbc_state_t st_q;
  logic [4:0] bit_q;
  logic [1:0] start_q;
  logic [15:0] tx_q, rx_q;
  logic [4:0] wlen;
  logic word_done;
  logic [15:0] rx_word, rx_next;
  assign wlen = test_audio_13bit ? 5'(WORD_TEST) : 5'(WORD_NORMAL);
  // bit_q counts serial periods after the sync period
  assign word_done = st_q == VBC_SHIFT && fall && bit_q == wlen;
  // push takes the word including the bit captured on this edge
  assign rx_next = {rx_q[14:0], voice_serial_in};
  // 13-bit words land in the upper bits of a 16-bit word
  assign rx_word = test_audio_13bit ? {rx_next[12:0], 3'h0} : rx_next;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= VBC_IDLE;
      bit_q <= '0;
      start_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      voice_frame_sync <= 1'b0;
    end else if (!run) begin
      st_q <= VBC_IDLE;
      start_q <= '0;
      voice_frame_sync <= 1'b0;
    end else if (rise) begin
      case (st_q)
        VBC_IDLE: st_q <= VBC_START;
        VBC_START: begin
          start_q <= start_q + 2'h1;
          if (start_q == 2'(STARTUP_FRAMES - 1)) st_q <= VBC_SYNC;
        end
        VBC_SYNC: begin
          voice_frame_sync <= 1'b1;
          st_q <= VBC_SHIFT;
          bit_q <= '0;
        end
        VBC_SHIFT: begin
          // sync period follows the last bit period, word starts one period later
          if (bit_q >= wlen) begin
            voice_frame_sync <= 1'b1;
            bit_q <= '0;
          end else begin
            voice_frame_sync <= 1'b0;
            bit_q <= bit_q + 5'h01;
          end
          if (bit_q == 5'h00) tx_q <= lp4;
          else tx_q <= {tx_q[14:0], 1'b0};
        end
        default: st_q <= VBC_IDLE;
      endcase
    end else if (fall && st_q == VBC_SHIFT && bit_q != 5'h00 && bit_q <= wlen) begin
      rx_q <= rx_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      voice_serial_clock <= 1'b0;
      voice_serial_out <= 1'b0;
      voice_serial_out_oe_n <= 1'b1;
    end else begin
      voice_serial_clock <= sclk_q;
      voice_serial_out <= tx_q[15];
      voice_serial_out_oe_n <= !run || serial_out_float;
    end
  end

  // ***************
  // two-entry buffer toward the dac path
  // ***************
  logic [15:0] buf_q [2];
  logic [1:0] cnt_q;
  logic rd_q, wr_q;
  logic push, pop;
  assign push = word_done && cnt_q != 2'h2; // full buffer drops incoming word
  assign pop = cnt_q != 2'h0 && dac_word_ready;
  assign dac_word = buf_q[rd_q];
  assign dac_word_valid = cnt_q != 2'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      cnt_q <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= rx_word;
        wr_q <= !wr_q;
      end
      if (pop) rd_q <= !rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ***************
  // dac modulator: first-order sigma-delta
  // ***************
  logic signed [17:0] sd_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_q <= '0;
      dac_mod_bit <= 1'b0;
    end else if (!run) begin
      sd_q <= '0;
      dac_mod_bit <= 1'b0;
    end else if (mod_tick) begin
      sd_q <= sd_q + 18'($signed(dac_word)) - (dac_mod_bit ? 18'sh08000 : -18'sh08000);
      dac_mod_bit <= !sd_q[17];
    end
  end

  // ***************
  // checks
  // ***************
  one_output_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0({normal_out_pair_en, aux_out_pair_en, buzzer_out_en})) else $error("two outputs on");
  mute_gain_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    output_mute |=> pga_gain == GAIN_MIN) else $error("mute not at min gain");
  buzzer_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    out_select != SEL_BUZZER |=> buzzer_oe_n) else $error("buzzer driven");
  disable_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outputs_disable |=> !pga_power_up && !normal_out_pair_en) else $error("outputs not off");
  float_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serial_out_float |=> voice_serial_out_oe_n) else $error("serial out driven");
  port_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !voice_power_up ##1 !voice_power_up |=> !voice_frame_sync) else $error("sync while off");
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frozen && run |=> $stable(half_cnt_q) && $stable(mod_cnt_q)) else $error("not frozen");
  soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    voice_soft_reset |=> st_q == VBC_IDLE) else $error("soft reset ignored");
  sync_period_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && voice_frame_sync |=> !voice_frame_sync) else $error("sync longer than one period");
  tx_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && st_q == VBC_SHIFT && bit_q == 5'h00 |=> tx_q == $past(lp4)) else $error("word not loaded");
  gain_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !output_mute |=> pga_gain == $past(out_gain)) else $error("gain code not applied");
endmodule

// [sim/vbc_dsp_model.sv]
// Purpose: baseband DSP at the far end of the voice serial port
// Assumes: device owns serial clock and frame sync
// Notes: sent word steps by 16'h1111 after every frame
`timescale 1ns/100ps
module vbc_dsp_model (
  // serial pins
  input wire logic voice_serial_clock,
  input wire logic voice_frame_sync,
  output logic voice_serial_in,
  // word control and status
  input wire logic test_audio_13bit,
  output logic [15:0] tx_word,
  output int frames_done
);
  logic armed = 1'b0;
  logic busy = 1'b0;
  int k = 0;
  initial begin
    voice_serial_in = 1'b0;
    tx_word = 16'h8421;
    frames_done = 0;
  end
  // ****************
  // bit shifting
  // ****************
  always @(posedge voice_serial_clock) begin
    if (armed) begin
      armed = 1'b0;
      busy = 1'b1;
      k = 0;
    end
    if (busy) begin
      voice_serial_in <= tx_word[15 - k];
    end
  end
  always @(negedge voice_serial_clock) begin
    if (busy) begin
      k = k + 1;
      if (k >= (test_audio_13bit ? 13 : 16)) begin
        busy = 1'b0;
        frames_done = frames_done + 1;
        tx_word = tx_word + 16'h1111;
        // released line shows the inverse of the last bit
        voice_serial_in <= ~voice_serial_in;
      end
    end
    if (voice_frame_sync) begin
      armed = 1'b1;
    end
  end
endmodule

// [sim/vbc_codec_port_test.sv]
// Purpose: self-checking bench for the voiceband codec port
// Assumes: DSP model on the serial pins, bench drives the controls
// Notes: inputs change on the falling edge of ref_clk
`timescale 1ns/100ps
module vbc_codec_port_test;
  import vbc_pkg::*;
  logic ref_clk, rst_n, outputs_disable, voice_power_up, output_mute, voice_clock_off;
  logic voice_soft_reset, test_audio_13bit, serial_out_float, adc_mod_bit, voice_serial_in;
  logic dac_word_ready, adc_mod_tick, dac_mod_bit, voice_serial_clock, voice_frame_sync;
  logic voice_serial_out, voice_serial_out_oe_n, normal_out_pair_en, aux_out_pair_en;
  logic buzzer_out_en, buzzer_oe_n, pga_power_up, dac_word_valid;
  logic [2:0] out_gain, pga_gain;
  logic [1:0] out_select;
  logic [4:0] serial_clock_divider;
  logic [15:0] dac_word, tx_word;
  int frames_done, n;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  vbc_codec_port DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .outputs_disable(outputs_disable), .out_gain(out_gain),
    .voice_power_up(voice_power_up), .out_select(out_select), .output_mute(output_mute),
    .voice_clock_off(voice_clock_off), .voice_soft_reset(voice_soft_reset),
    .test_audio_13bit(test_audio_13bit), .serial_out_float(serial_out_float),
    .serial_clock_divider(serial_clock_divider), .adc_mod_bit(adc_mod_bit), .adc_mod_tick(adc_mod_tick),
    .dac_mod_bit(dac_mod_bit), .voice_serial_clock(voice_serial_clock), .voice_frame_sync(voice_frame_sync),
    .voice_serial_out(voice_serial_out), .voice_serial_out_oe_n(voice_serial_out_oe_n),
    .voice_serial_in(voice_serial_in), .normal_out_pair_en(normal_out_pair_en),
    .aux_out_pair_en(aux_out_pair_en), .buzzer_out_en(buzzer_out_en), .buzzer_oe_n(buzzer_oe_n),
    .pga_gain(pga_gain), .pga_power_up(pga_power_up), .dac_word(dac_word),
    .dac_word_valid(dac_word_valid), .dac_word_ready(dac_word_ready)
  );
  vbc_dsp_model u_dsp (
    .voice_serial_clock(voice_serial_clock), .voice_frame_sync(voice_frame_sync),
    .voice_serial_in(voice_serial_in), .test_audio_13bit(test_audio_13bit), .tx_word(tx_word),
    .frames_done(frames_done)
  );

  // ****************
  // clock, timeout, modulator stimulus
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (adc_mod_tick === 1'b1) adc_mod_bit <= ~adc_mod_bit;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: timeout", $time);
      end_of_test;
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cycles until the next rising frame sync, minus one
  task automatic sync_rise(output int c);
    logic prev;
    c = 0;
    prev = voice_frame_sync;
    @(negedge ref_clk);
    while (!(voice_frame_sync && !prev) && c < 4000) begin
      prev = voice_frame_sync;
      @(negedge ref_clk);
      c++;
    end
  endtask
  task automatic frame_chk(input logic [4:0] div, input logic tam, input int per);
    int c;
    serial_clock_divider = div;
    test_audio_13bit = tam;
    repeat (3) sync_rise(c);
    check(16'(c + 1), 16'((tam ? 14 : 17) * per), "frame length");
  endtask
  task automatic wait_frames(input int more);
    int target;
    int c;
    target = frames_done + more;
    c = 0;
    while (frames_done < target && c < 20000) begin
      @(negedge ref_clk);
      c++;
    end
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic buf_chk(input logic tam);
    logic [15:0] w;
    logic [15:0] m;
    m = tam ? 16'hfff8 : 16'hffff;
    test_audio_13bit = tam;
    serial_clock_divider = 5'h00;
    dac_word_ready = 1'b1;
    wait_frames(2);
    dac_word_ready = 1'b0;
    w = tx_word;
    wait_frames(3);
    check(16'(dac_word_valid), 16'h0001, "held word");
    check(dac_word, w & m, "first word");
    dac_word_ready = 1'b1;
    @(negedge ref_clk);
    dac_word_ready = 1'b0;
    check(dac_word, (w + 16'h1111) & m, "second word");
    dac_word_ready = 1'b1;
    @(negedge ref_clk);
    dac_word_ready = 1'b0;
    check(16'(dac_word_valid), 16'h0000, "third word dropped");
  endtask
  task automatic quiet_chk(input logic idle);
    int t;
    logic p;
    t = 0;
    repeat (4) @(negedge ref_clk);
    p = voice_serial_clock;
    repeat (300) begin
      @(negedge ref_clk);
      if (voice_serial_clock !== p) t++;
      p = voice_serial_clock;
    end
    check(16'(t), 16'h0000, "serial clock still");
    if (idle) check(16'({voice_frame_sync, voice_serial_out_oe_n}), 16'h0001, "port idle");
  endtask

  initial begin
    {rst_n, outputs_disable, voice_power_up, output_mute, voice_clock_off, voice_soft_reset} = 6'h00;
    {test_audio_13bit, serial_out_float, adc_mod_bit, out_gain, out_select} = 8'h00;
    serial_clock_divider = 5'h00;
    dac_word_ready = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(16'(normal_out_pair_en | aux_out_pair_en | buzzer_out_en), 16'h0000, "reset enables");
    check(16'(voice_serial_out_oe_n & buzzer_oe_n), 16'h0001, "reset oe");
    check(16'({voice_frame_sync, dac_word_valid, pga_gain}), 16'(GAIN_MIN), "reset state");
    rst_n = 1'b1;
    @(negedge ref_clk);
    voice_power_up = 1'b1;
    for (int i = 0; i < 128; i++) begin
      out_select = i[1:0];
      out_gain = i[4:2];
      output_mute = i[5];
      outputs_disable = i[6];
      repeat (2) @(negedge ref_clk);
      check(16'(normal_out_pair_en), 16'(i[1:0] == SEL_NORMAL && !i[6]), "normal");
      check(16'(aux_out_pair_en), 16'(i[1:0] == SEL_AUX && !i[6]), "aux");
      check(16'(buzzer_out_en), 16'(i[1:0] == SEL_BUZZER && !i[6]), "buzzer");
      check(16'(buzzer_oe_n), 16'(i[1:0] != SEL_BUZZER || i[6]), "buzzer float");
      check(16'(pga_power_up), 16'(!i[6]), "pga power");
      if (!i[6]) check(16'(pga_gain), 16'(i[5] ? GAIN_MIN : i[4:2]), "gain");
    end
    output_mute = 1'b1;
    outputs_disable = 1'b0;
    out_gain = 3'h0;
    @(negedge ref_clk);
    out_select = SEL_NONE;
    @(negedge ref_clk);
    out_select = SEL_AUX;
    @(negedge ref_clk);
    output_mute = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(16'({aux_out_pair_en, pga_gain}), 16'h0008, "aux switched");
    $display("test outputs done");
    n = 0;
    while (adc_mod_tick !== 1'b1 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    n = 1;
    while (adc_mod_tick !== 1'b1 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(n), 16'(MOD_DIV), "modulator tick");
    $display("test modulator done");
    frame_chk(5'h00, 1'b0, 5);
    frame_chk(5'h01, 1'b0, 10);
    frame_chk(DIV_MAX_NORMAL, 1'b0, 85);
    frame_chk(DIV_TEST_EXTRA, 1'b1, 125);
    frame_chk(DIV_TEST_EXTRA, 1'b0, 85);
    frame_chk(5'h02, 1'b1, 15);
    $display("test frame timing done");
    buf_chk(1'b0);
    buf_chk(1'b1);
    $display("test receive buffer done");
    serial_out_float = 1'b1;
    sync_rise(n);
    repeat (15) @(negedge ref_clk);
    check(16'(voice_serial_out_oe_n), 16'h0001, "out floats");
    serial_out_float = 1'b0;
    sync_rise(n);
    repeat (15) @(negedge ref_clk);
    check(16'({voice_serial_out_oe_n, voice_serial_out}), 16'h0000, "out drives");
    voice_power_up = 1'b0;
    quiet_chk(1'b1);
    voice_power_up = 1'b1;
    voice_clock_off = 1'b1;
    quiet_chk(1'b0);
    voice_clock_off = 1'b0;
    voice_soft_reset = 1'b1;
    quiet_chk(1'b1);
    voice_soft_reset = 1'b0;
    test_audio_13bit = 1'b0;
    sync_rise(n);
    sync_rise(n);
    check(16'(n + 1), 16'h0055, "restart frame");
    $display("test port control done");
    end_of_test;
  end
endmodule
